// *** logic/external_memory_page_wait_ctrl.sv ***
// Purpose: page mapping, upper address pins and per-region wait control
// Assumes: APB slave; cpu request held until cpu_ready
// Notes: one access at a time; strobes and selects come from flip-flops
// Functional notes
// - paged window accesses carry that window's page register as high bits
// - page register holds bits 28..13; low nine bits go to page pins
// - in SRAM mode only page bits 17..13 are driven
// - paged window accesses assert the paged-space select, active low
// - upper enable bit 3 gates A18..15; resets disabled
// - A18..15 are driven high from power-up
// - wait states are counted in 48 MHz periods
// - RAM merge bit 13 makes RAM select follow paged select
// - ROM merge bit 12 makes ROM select follow paged select
// - bit 11 picks paged width: 1 is 8-bit, 0 is 16-bit
// - bits 10..8 give paged wait states 0 to 7
// - bit 7 picks ROM width: 1 is 8-bit, 0 is 16-bit
// - bits 6..4 give ROM wait states 0 to 7
// - bit 3 picks RAM width: 1 is 8-bit, 0 is 16-bit
// - bits 2..0 give RAM wait states 0 to 7
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "ext_mem_consts.svh"
module external_memory_page_wait_ctrl
  import ext_mem_pkg::*;
(
  input wire logic pclk, // clock, 10 MHz
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [19:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire cpu_req_t cpu_req, // cpu access request
  output logic cpu_ready, // access complete pulse
  output logic [15:0] cpu_rdata, // read data of last access
  output mem_pins_t pins, // external address, selects, strobes
  input wire logic [15:0] data_in, // external data pins, input side
  output logic [15:0] data_out, // external data pins, output side
  output logic data_oe_n // data pin enable, low while driving
);

  // ========================================================================
  // declarations
  logic [15:0] page_one_high_address;
  logic [15:0] page_two_high_address;
  logic upper_address_pin_enable;
  logic [13:0] memory_width_wait_control;
  logic sram_mode;
  logic [31:0] next_prdata;
  logic rd_fresh;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  access_state_t state;
  logic start;
  logic expired;
  logic hit_one;
  logic hit_paged;
  logic [15:0] page_sel;
  logic [2:0] sel_wait;
  logic sel_narrow;
  logic [18:0] next_addr;
  logic [8:0] next_page_bits;
  logic cur_paged;
  logic cur_ram;
  logic cur_rom;
  logic cur_narrow;
  logic [3:0] cur_wait;
  logic [15:0] data_meta;
  logic [15:0] data_sync;
  logic ram_select_merge;
  logic rom_select_merge;

  assign ram_select_merge = memory_width_wait_control[`RAM_MERGE_BIT];
  assign rom_select_merge = memory_width_wait_control[`ROM_MERGE_BIT];

  // ========================================================================
  // helpers
  function automatic logic [2:0] reg_sel(input logic [19:0] a);
    reg_sel = 3'h0;
    if (a == `BYTE_ADDR(`IDX_PAGE_ONE)) reg_sel = 3'h1;
    if (a == `BYTE_ADDR(`IDX_PAGE_TWO)) reg_sel = 3'h2;
    if (a == `BYTE_ADDR(`IDX_UPPER_EN)) reg_sel = 3'h3;
    if (a == `BYTE_ADDR(`IDX_MEM_CTRL)) reg_sel = 3'h4;
    if (a == `BYTE_ADDR(`IDX_MODE)) reg_sel = 3'h5;
    if (a == `BYTE_ADDR(`IDX_STATUS)) reg_sel = 3'h6;
  endfunction

  function automatic logic [3:0] wait_pclks(input logic [2:0] ws);
    wait_pclks = 4'(`WAIT_PCLKS(32'(ws)));
  endfunction

  // ========================================================================
  // APB register file
  assign wr_sel = reg_sel(paddr);
  assign rd_sel = reg_sel(paddr);
  // reads come from a flop loaded in the setup phase
  assign pready = ce & (pwrite | rd_fresh);
  assign pslverr = psel & penable & (wr_sel == 3'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_one_high_address <= `PAGE_RESET;
      page_two_high_address <= `PAGE_RESET;
      upper_address_pin_enable <= `UPPER_EN_RESET;
      memory_width_wait_control <= `MEM_CTRL_RESET;
      sram_mode <= 1'h0;
    end else if (ce && psel && penable && pwrite) begin
      unique case (wr_sel)
        3'h1: page_one_high_address <= pwdata[15:0];
        3'h2: page_two_high_address <= pwdata[15:0];
        3'h3: upper_address_pin_enable <= pwdata[`UPPER_EN_BIT];
        3'h4: memory_width_wait_control <= pwdata[13:0];
        3'h5: sram_mode <= pwdata[`SRAM_MODE_BIT];
        default: ;
      endcase
    end
  end

  always_comb begin
    next_prdata = 32'h00000000;
    unique case (rd_sel)
      3'h1: next_prdata[15:0] = page_one_high_address;
      3'h2: next_prdata[15:0] = page_two_high_address;
      3'h3: next_prdata[`UPPER_EN_BIT] = upper_address_pin_enable;
      3'h4: next_prdata[13:0] = memory_width_wait_control;
      3'h5: next_prdata[`SRAM_MODE_BIT] = sram_mode;
      3'h6: next_prdata[3:0] = {cur_rom, cur_ram, cur_paged,
                                state != ST_IDLE};
      default: ;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      rd_fresh <= 1'h0;
    end else if (ce) begin
      rd_fresh <= psel;
      if (psel) begin
        prdata <= next_prdata;
      end
    end
  end

  // ========================================================================
  // access decode
  assign start = (state == ST_IDLE) & cpu_req.valid;
  assign hit_one = (cpu_req.addr[15:13] == `PAGE_ONE_TOP);
  assign hit_paged = hit_one | (cpu_req.addr[15:13] == `PAGE_TWO_TOP);
  assign page_sel = hit_one ? page_one_high_address : page_two_high_address;

  always_comb begin
    if (hit_paged) begin
      sel_wait = memory_width_wait_control[`PAGED_WAIT_LSB +: 3];
      sel_narrow = memory_width_wait_control[`PAGED_WIDTH_BIT];
    end else if (cpu_req.rom_hit) begin
      sel_wait = memory_width_wait_control[`ROM_WAIT_LSB +: 3];
      sel_narrow = memory_width_wait_control[`ROM_WIDTH_BIT];
    end else begin
      sel_wait = memory_width_wait_control[`RAM_WAIT_LSB +: 3];
      sel_narrow = memory_width_wait_control[`RAM_WIDTH_BIT];
    end
  end

  always_comb begin
    next_addr = {3'h0, cpu_req.addr};
    next_page_bits = page_sel[8:0];
    // page bits above the window offset
    if (hit_paged) begin
      next_addr = {page_sel[5:0], cpu_req.addr[12:0]};
    end
    // SRAM mode drives page bits 17..13 only
    if (sram_mode) begin
      next_page_bits = {4'h0, page_sel[4:0]};
      if (hit_paged) begin
        next_addr = {1'h0, page_sel[4:0], cpu_req.addr[12:0]};
      end
    end
  end

  // ========================================================================
  // access sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else if (ce) begin
      unique case (state)
        ST_IDLE: if (start) state <= ST_STROBE;
        // strobe held until the extra cycles run out
        ST_STROBE: if (expired) state <= ST_FINISH;
        ST_FINISH: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign cpu_ready = (state == ST_FINISH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_paged <= 1'h0;
      cur_ram <= 1'h0;
      cur_rom <= 1'h0;
      cur_narrow <= 1'h0;
      cur_wait <= 4'h0;
    end else if (ce && start) begin
      cur_paged <= hit_paged;
      cur_ram <= cpu_req.ram_hit & !hit_paged;
      cur_rom <= cpu_req.rom_hit & !hit_paged;
      cur_narrow <= sel_narrow;
      // wait states converted from wait clock periods
      cur_wait <= wait_pclks(sel_wait);
    end
  end

  wait_strobe_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .load(start),
    .load_cycles(wait_pclks(sel_wait)),
    .expired(expired)
  );

  // ========================================================================
  // pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= '{addr: `PINS_ADDR_RESET, page_bits: 9'h000,
                paged_space_chip_select_n: 1'h1,
                ext_ram_chip_select_n: 1'h1,
                ext_rom_chip_select_n: 1'h1,
                read_strobe_n: 1'h1, write_strobe_n: 1'h1,
                narrow_bus: 1'h0};
      data_out <= 16'h0000;
      data_oe_n <= 1'h1;
    end else if (ce) begin
      if (start) begin
        pins.addr[14:0] <= next_addr[14:0];
        pins.page_bits <= hit_paged ? next_page_bits : 9'h000;
        pins.narrow_bus <= sel_narrow;
        // paged select for the paged window
        pins.paged_space_chip_select_n <= !hit_paged;
        // merged selects follow the paged select
        pins.ext_ram_chip_select_n <= !((cpu_req.ram_hit & !hit_paged) |
                                        (hit_paged & ram_select_merge));
        pins.ext_rom_chip_select_n <= !((cpu_req.rom_hit & !hit_paged) |
                                        (hit_paged & rom_select_merge));
        pins.read_strobe_n <= cpu_req.write;
        pins.write_strobe_n <= !cpu_req.write;
        data_out <= sel_narrow ? {8'h00, cpu_req.wdata[7:0]}
                               : cpu_req.wdata;
        data_oe_n <= !cpu_req.write;
      end else if (state == ST_STROBE && expired) begin
        pins.paged_space_chip_select_n <= 1'h1;
        pins.ext_ram_chip_select_n <= 1'h1;
        pins.ext_rom_chip_select_n <= 1'h1;
        pins.read_strobe_n <= 1'h1;
        pins.write_strobe_n <= 1'h1;
        data_oe_n <= 1'h1;
      end
      // upper pins stay high unless enabled
      if (!upper_address_pin_enable) begin
        pins.addr[18:15] <= 4'hF;
      end else if (start) begin
        pins.addr[18:15] <= next_addr[18:15];
      end
    end
  end

  // ========================================================================
  // read data: pins are asynchronous, so two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_meta <= 16'h0000;
      data_sync <= 16'h0000;
      cpu_rdata <= 16'h0000;
    end else if (ce) begin
      data_meta <= data_in;
      data_sync <= data_meta;
      if (state == ST_STROBE && expired) begin
        cpu_rdata <= cur_narrow ? {8'h00, data_sync[7:0]} : data_sync;
      end
    end
  end

  // ========================================================================
  // checks
  logic strobe_on;
  logic [3:0] strobe_len;
  assign strobe_on = !pins.read_strobe_n | !pins.write_strobe_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_len <= 4'h0;
    end else if (ce) begin
      strobe_len <= strobe_on ? strobe_len + 4'h1 : 4'h0;
    end
  end

  sequence s_begin;
    (state == ST_IDLE) && cpu_req.valid && ce;
  endsequence

  sequence s_strobe_up;
    strobe_on && (state == ST_STROBE);
  endsequence

  AST_STROBE_START: assert property (
    @(posedge pclk) disable iff (!presetn) s_begin |=> s_strobe_up)
    else $error("strobe did not start after request");

  AST_STROBE_LEN: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(strobe_on) |-> strobe_len == cur_wait + 4'h1)
    else $error("strobe length differs from programmed waits");

  AST_WAIT_UNIT: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_begin and (sel_wait == 3'h7) |=> cur_wait == 4'h2)
    else $error("seven wait periods not two pclk cycles");

  AST_PAGE_ADDR: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_begin and (hit_one && !sram_mode) |=>
    pins.page_bits == $past(page_one_high_address[8:0]) &&
    pins.addr[12:0] == $past(cpu_req.addr[12:0]))
    else $error("paged address not built from page register");

  AST_SRAM_PAGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    sram_mode && $past(sram_mode) && !pins.paged_space_chip_select_n
    |-> pins.page_bits[8:5] == 4'h0)
    else $error("sram mode drove page bits above 17");

  AST_PAGED_SELECT: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_begin and (hit_paged) |=> !pins.paged_space_chip_select_n [*1] ##0
    strobe_on)
    else $error("paged select missing on paged access");

  AST_UPPER_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    !upper_address_pin_enable && $past(!upper_address_pin_enable)
    && $past(ce) |-> pins.addr[18:15] == 4'hF)
    else $error("upper address pins driven while disabled");

  AST_UPPER_INIT: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> pins.addr[18:15] == 4'hF)
    else $error("upper address pins not high after reset");

  AST_RAM_MERGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pins.paged_space_chip_select_n && $past(ram_select_merge)
    && $past(start) |-> !pins.ext_ram_chip_select_n)
    else $error("ram select not merged with paged select");

  AST_ROM_MERGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pins.paged_space_chip_select_n && $past(rom_select_merge)
    && $past(start) |-> !pins.ext_rom_chip_select_n)
    else $error("rom select not merged with paged select");

  AST_WIDTH: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_begin and (hit_paged) |=> pins.narrow_bus ==
    $past(memory_width_wait_control[`PAGED_WIDTH_BIT]))
    else $error("paged bus width not as programmed");

endmodule

// *** logic/ext_mem_consts.svh ***
// Purpose: offsets, fields, reset values and timing of the memory control
// Assumes: register indices are scaled by four onto the APB byte address
// Notes: definitions only
`ifndef EXT_MEM_CONSTS_SVH
`define EXT_MEM_CONSTS_SVH

// ==========================================================================
// register indices and byte addresses
`define IDX_PAGE_ONE 16'hC018
`define IDX_PAGE_TWO 16'hC01A
`define IDX_UPPER_EN 16'hC038
`define IDX_MEM_CTRL 16'hC03A
`define IDX_MODE 16'hC040
`define IDX_STATUS 16'hC042
`define BYTE_ADDR(i) ({2'h0, (i), 2'h0})

// ==========================================================================
// field positions and window tops
`define UPPER_EN_BIT 3
`define RAM_MERGE_BIT 13
`define ROM_MERGE_BIT 12
`define PAGED_WIDTH_BIT 11
`define PAGED_WAIT_LSB 8
`define ROM_WIDTH_BIT 7
`define ROM_WAIT_LSB 4
`define RAM_WIDTH_BIT 3
`define RAM_WAIT_LSB 0
`define SRAM_MODE_BIT 0
`define PAGE_ONE_TOP 3'h4
`define PAGE_TWO_TOP 3'h5

// ==========================================================================
// reset values
`define PAGE_RESET 16'h0000
`define UPPER_EN_RESET 1'h0
`define MEM_CTRL_RESET 14'h0000
`define PINS_ADDR_RESET 19'h78000

// ==========================================================================
// timing: wait states tick at the wait clock, rounded up to pclk cycles
`define PCLK_HZ 10000000
`define WAIT_CLK_HZ 48000000
`define WAIT_PCLKS(ws) (((ws) * `PCLK_HZ + `WAIT_CLK_HZ - 1) / `WAIT_CLK_HZ)

`endif

// *** logic/ext_mem_pkg.sv ***
// Purpose: types shared by the memory control block
// Assumes: nothing
// Notes: pin group and cpu request travel as packed structs
package ext_mem_pkg;

  // ========================================================================
  // types
  typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_FINISH} access_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic ram_hit;
    logic rom_hit;
  } cpu_req_t;

  typedef struct packed {
    logic [18:0] addr;
    logic [8:0] page_bits;
    logic paged_space_chip_select_n;
    logic ext_ram_chip_select_n;
    logic ext_rom_chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic narrow_bus;
  } mem_pins_t;

endpackage

// *** logic/wait_strobe_timer.sv ***
// Purpose: counts the extra strobe cycles of one external access
// Assumes: load only while idle
// Notes: expired is high whenever the count is zero
`timescale 1ns/1ps
module wait_strobe_timer (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic load, // start of an access
  input wire logic [3:0] load_cycles, // extra cycles to hold
  output logic expired // count reached zero
);

  logic [3:0] count;

  // ========================================================================
  // countdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 4'h0;
    end else if (ce) begin
      if (load) begin
        count <= load_cycles;
      end else if (count != 4'h0) begin
        count <= count - 4'h1;
      end
    end
  end

  assign expired = (count == 4'h0);

endmodule

// *** verification/ext_mem_model.sv ***
// Purpose: external memory on the pin side of the memory control block
// Assumes: selects and strobes are active low, sampled at pclk
// Notes: a released data bus shows the inverse of its last value
`timescale 1ns/1ps
module ext_mem_model
  import ext_mem_pkg::*;
(
  input wire logic pclk, // clock
  input wire mem_pins_t pins, // address, selects, strobes
  input wire logic [15:0] data_out, // device write data
  input wire logic data_oe_n, // low while device drives
  output logic [15:0] data_in // data towards device
);
  // ==========
  // storage
  logic [15:0] mem [logic [18:0]];
  logic [15:0] last = 16'h0000;
  logic sel;
  logic rd;

  assign sel = !(pins.paged_space_chip_select_n &
                 pins.ext_ram_chip_select_n & pins.ext_rom_chip_select_n);
  assign rd = sel && !pins.read_strobe_n;

  always @(posedge pclk) begin
    if (sel && !pins.write_strobe_n && !data_oe_n) begin
      mem[pins.addr] = data_out;
    end
    if (rd) begin
      last <= data_in;
    end
  end

  // inverse when idle, so a late sample cannot pass by luck
  always @* begin
    if (rd) begin
      data_in = mem.exists(pins.addr) ? mem[pins.addr] : 16'hA5C3;
    end else begin
      data_in = ~last;
    end
  end
endmodule

// *** verification/tb.sv ***
// Purpose: self-checking bench for the memory control block
// Assumes: ce held high; expectations from a register and memory model
// Notes: read data only compared when the strobe spans three cycles
`timescale 1ns/1ps
`include "ext_mem_consts.svh"
module tb;
  import ext_mem_pkg::*;
  // ==========
  // signals and model state
  localparam logic [19:0] a_pg1 = `BYTE_ADDR(`IDX_PAGE_ONE);
  localparam logic [19:0] a_pg2 = `BYTE_ADDR(`IDX_PAGE_TWO);
  localparam logic [19:0] a_up = `BYTE_ADDR(`IDX_UPPER_EN);
  localparam logic [19:0] a_ctl = `BYTE_ADDR(`IDX_MEM_CTRL);
  localparam logic [19:0] a_mode = `BYTE_ADDR(`IDX_MODE);
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [19:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, cpu_ready, data_oe_n;
  cpu_req_t cpu_req = '0;
  mem_pins_t pins;
  logic [15:0] cpu_rdata, data_in, data_out, v, a;
  logic [15:0] pg [2] = '{16'h0000, 16'h0000};
  logic [15:0] upen = 0, ctrl = 0, mode = 0;
  logic [15:0] mem [logic [18:0]];
  int fails = 0, checks_done = 0, cyc = 0, seed = 48;

  always #50 pclk = ~pclk;

  external_memory_page_wait_ctrl u_external_memory_page_wait_ctrl (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_req(cpu_req), .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata),
    .pins(pins), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n));
  ext_mem_model u_ext_mem_model (.pclk(pclk), .pins(pins),
    .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in));

  // ==========
  // tasks
  task automatic check(input logic [32:0] s, input logic [32:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [19:0] ad,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for pready at a rising edge; only the bench timeout ends it
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] exp_reg(input logic [19:0] ad);
    case (ad)
      a_pg1: return pg[0];
      a_pg2: return pg[1];
      a_up: return upen;
      a_ctl: return ctrl;
      a_mode: return mode;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic wr(input logic [19:0] ad, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, ad, {16'h0000, d}, r, e);
    case (ad)
      a_pg1: pg[0] = d;
      a_pg2: pg[1] = d;
      a_up: upen = d & 16'h0008;
      a_ctl: ctrl = d & 16'h3FFF;
      a_mode: mode = d & 16'h0001;
      default: ;
    endcase
    apb(1'b0, ad, 32'h0, r, e);
    check({e, r}, {17'h0, exp_reg(ad)});
  endtask

  task automatic cpu(input logic w, input logic [15:0] ad, d,
                     input logic rh, oh);
    int ws, wt, n, low;
    logic ph, nar;
    logic [15:0] p, ex;
    logic [18:0] ea;
    ph = ad[15:14] == 2'b10;
    p = pg[ad[13]];
    ws = ph ? ctrl[10:8] : (rh ? ctrl[2:0] : ctrl[6:4]);
    nar = ph ? ctrl[11] : (rh ? ctrl[3] : ctrl[7]);
    wt = (ws * 10 + 47) / 48;
    ea = mode[0] ? {1'b0, p[4:0], ad[12:0]} : {p[5:0], ad[12:0]};
    if (!upen[3]) ea[18:15] = 4'hF;
    ex = nar ? {8'h00, d[7:0]} : d;
    n = 0;
    low = 0;
    @(posedge pclk);
    cpu_req <= '{1'b1, w, ad, d, rh, oh};
    while (cpu_ready !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
      if ((w ? pins.write_strobe_n : pins.read_strobe_n) === 1'b0) begin
        if (low == 0) begin
          check({pins.paged_space_chip_select_n, pins.ext_ram_chip_select_n,
                 pins.ext_rom_chip_select_n, pins.narrow_bus},
                {!ph, !(rh || ph && ctrl[13]), !(oh || ph && ctrl[12]),
                 nar});
          check(pins.page_bits, !ph ? 9'h0 : mode[0] ?
                {4'h0, p[4:0]} : p[8:0]);
          if (ph) check(pins.addr, ea);
          if (w) check({data_oe_n, data_out}, {1'b0, ex});
        end
        low++;
      end
    end
    check(n, 3 + wt);
    check(low, 1 + wt);
    if (w && ph) mem[ea] = ex;
    if (!w && ph && wt == 2 && mem.exists(ea)) begin
      check(cpu_rdata, nar ? {8'h00, mem[ea][7:0]} : mem[ea]);
    end
    @(posedge pclk);
    cpu_req.valid <= 1'b0;
  endtask

  // ==========
  // timeout and main sequence
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    logic [31:0] r;
    logic e;
    repeat (3) @(negedge pclk);
    check(pins.addr, 19'h78000);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, a_pg1, 32'h0, r, e);
    check({e, r}, 33'h0);
    apb(1'b0, a_pg2, 32'h0, r, e);
    check({e, r}, 33'h0);
    apb(1'b0, a_up, 32'h0, r, e);
    check({e, r}, 33'h0);
    for (int i = 0; i < 4; i++) begin
      wr(i[0] ? a_pg2 : a_pg1, 16'($random(seed)) & 16'hFEFF);
    end
    wr(a_up, 16'h0008);
    apb(1'b1, 20'h30004, 32'hFFFF, r, e);
    check(e, 1'b1);
    apb(1'b0, 20'h30004, 32'h0, r, e);
    check({e, r}, 33'h100000000);
    $display("test registers done");
    for (int ws = 0; ws < 8; ws++) begin
      v = 16'($random(seed));
      v[15:14] = 2'b00;
      v[10:8] = 3'(ws);
      v[6:4] = 3'(ws);
      v[2:0] = 3'(ws);
      wr(a_ctl, v);
      wr(a_up, ws[0] ? 16'h0008 : 16'h0000);
      wr(a_mode, 16'(ws[1]));
      a = 16'($random(seed));
      cpu(1'b0, {2'b10, a[13:0]}, 16'h0, 1'b0, 1'b0);
      cpu(ws[2], a & 16'h7FFF, a, 1'b0, 1'b1);
      cpu(!ws[2], a & 16'h3FFF, ~a, 1'b1, 1'b0);
    end
    $display("test wait states done");
    for (int i = 0; i < 6; i++) begin
      v = 16'($random(seed)) | 16'h0777;
      v[15:14] = 2'b00;
      wr(a_ctl, v);
      wr(a_up, i[0] ? 16'h0008 : 16'h0000);
      wr(a_mode, 16'(i[1]));
      wr(i[0] ? a_pg2 : a_pg1, 16'($random(seed)) & 16'hFEFF);
      a = 16'($random(seed));
      a[15:13] = {2'b10, i[0]};
      cpu(1'b1, a, 16'($random(seed)), 1'b0, 1'b0);
      cpu(1'b0, a, 16'h0, 1'b0, 1'b0);
    end
    $display("test paged round trip done");
    tally_and_finish();
  end
endmodule
